// >>> hw/acs_pkg.sv
// constants, types and register map of the channel sequencer
//
// How it works
// - one enabled channel is converted over and over, never stepping away
// - several enabled channels are visited in ascending order, lowest to highest
// - each selected channel applies its setup slot and its conversion count
// - an all-zero enable mask makes channel 0 the active channel
// - writing the enable or any setup register resets filter, control and sequencer
// - enable mask is 16 bits, bit n enables channel n, reset 0x0001
// - sixteen setup registers from 0x80 in steps of 4 up to 0xBC, reset zero
// - setup bits [2:0] pick one of eight setup slots
// - the chosen slot supplies front end, filter, misc, offset and gain
// - repeat bits [15:8] add extra conversions, zero gives exactly one
// - after each channel switch wait the settling interval in modulator periods
// - delay code 000 waits nothing, 001 waits 16 modulator periods
package acs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  OFF_CH_EN      = 8'h78;
  localparam logic [7:0]  OFF_SETUP_BASE = 8'h80;
  localparam logic [7:0]  OFF_SETUP_LAST = 8'hBC;
  localparam logic [7:0]  OFF_CTRL       = 8'hC0;
  localparam logic [7:0]  OFF_STAT       = 8'hC4;
  localparam logic [15:0] CH_EN_RST      = 16'h0001;
  localparam logic [15:0] SETUP_RST      = 16'h0000;
  localparam logic [15:0] SETUP_WMASK    = 16'hFF77;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------
  // setup register fields
  // ----------------------------------------
  localparam int SLOT_LSB = 0;
  localparam int SLOT_W   = 3;
  localparam int DLY_LSB  = 4;
  localparam int DLY_W    = 3;
  localparam int REP_LSB  = 8;
  localparam int REP_W    = 8;

  // ----------------------------------------
  // control and status fields
  // ----------------------------------------
  localparam int CTRL_RUN_BIT  = 0;
  localparam int ST_CHAN_LSB   = 0;
  localparam int ST_SLOT_LSB   = 4;
  localparam int ST_SETTLE_BIT = 8;
  localparam int ST_CONV_BIT   = 9;
  localparam int ST_RUN_BIT    = 10;
  localparam int ST_REP_LSB    = 16;

  // ----------------------------------------
  // settling timing, in modulator periods
  // ----------------------------------------
  localparam int         MOD_DIV        = 4;
  localparam logic [1:0] MOD_DIV_LAST   = 2'(MOD_DIV - 1);
  localparam int         CNT_W          = 15;
  localparam int         DLY_C1_PERIODS = 16;
  localparam int         DLY_C2_PERIODS = 1024;
  localparam int         DLY_C3_PERIODS = 2048;
  localparam int         DLY_C4_PERIODS = 4096;
  localparam int         DLY_C5_PERIODS = 16384;

  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_SETTLE, ST_CONV} acs_state_t;

endpackage

// >>> hw/acs_core_if.sv
// internal carrier between sequencer, setup memory and settling timer
`timescale 1ns/10ps
`default_nettype none
interface acs_core_if;
  logic        we;
  logic [3:0]  waddr;
  logic [15:0] wdata;
  logic [1:0]  wbe;
  logic [3:0]  bus_raddr;
  logic [15:0] bus_rdata;
  logic [3:0]  seq_raddr;
  logic [15:0] seq_rdata;
  logic        tmr_start;
  logic [2:0]  tmr_code;
  logic        tmr_busy;

  modport mem (input we, waddr, wdata, wbe, bus_raddr, seq_raddr, output bus_rdata, seq_rdata);
  modport tmr (input tmr_start, tmr_code, output tmr_busy);
  modport ctl (output we, waddr, wdata, wbe, bus_raddr, seq_raddr, tmr_start, tmr_code,
               input bus_rdata, seq_rdata, tmr_busy);
endinterface
`default_nettype wire

// >>> hw/acs_setup_mem.sv
// sixteen per-channel setup words with two registered read ports
`timescale 1ns/10ps
`default_nettype none
module acs_setup_mem (
  input wire logic aclk,
  input wire logic aresetn,
  acs_core_if.mem  m
);

  logic [15:0] cfg_reg [16];

  // ----------------------------------------
  // storage, byte lanes, reserved bits held low
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_word
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          cfg_reg[g] <= acs_pkg::SETUP_RST;
        else if (m.we && m.waddr == 4'(g))
        begin
          if (m.wbe[0])
            cfg_reg[g][7:0] <= m.wdata[7:0] & acs_pkg::SETUP_WMASK[7:0];
          if (m.wbe[1])
            cfg_reg[g][15:8] <= m.wdata[15:8];
        end
      end
    end
  endgenerate

  // registered read ports
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      m.bus_rdata <= acs_pkg::SETUP_RST;
      m.seq_rdata <= acs_pkg::SETUP_RST;
    end
    else
    begin
      m.bus_rdata <= cfg_reg[m.bus_raddr];
      m.seq_rdata <= cfg_reg[m.seq_raddr];
    end
  end

endmodule
`default_nettype wire

// >>> hw/acs_settle_timer.sv
// settling delay counter ticking at the modulator rate
`timescale 1ns/10ps
`default_nettype none
module acs_settle_timer #(
  parameter int unsigned DLY_C3 = acs_pkg::DLY_C3_PERIODS,
  parameter int unsigned DLY_C4 = acs_pkg::DLY_C4_PERIODS,
  parameter int unsigned DLY_C5 = acs_pkg::DLY_C5_PERIODS
) (
  input wire logic aclk,
  input wire logic aresetn,
  acs_core_if.tmr  t
);

  logic [1:0]                 pre_reg;
  logic [acs_pkg::CNT_W-1:0]  cnt_reg;

  // delay code to modulator periods
  function automatic logic [acs_pkg::CNT_W-1:0] periods(input logic [2:0] code);
    case (code)
      3'h1:    periods = acs_pkg::CNT_W'(acs_pkg::DLY_C1_PERIODS);
      3'h2:    periods = acs_pkg::CNT_W'(acs_pkg::DLY_C2_PERIODS);
      3'h3:    periods = acs_pkg::CNT_W'(DLY_C3);
      3'h4:    periods = acs_pkg::CNT_W'(DLY_C4);
      3'h5:    periods = acs_pkg::CNT_W'(DLY_C5);
      default: periods = '0;
    endcase
  endfunction

  // ----------------------------------------
  // modulator tick, aligned to each start
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || t.tmr_start)
      pre_reg <= 2'h0;
    else
      pre_reg <= pre_reg + 2'h1;
  end

  // period countdown
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (t.tmr_start)
      cnt_reg <= periods(t.tmr_code);
    else if (cnt_reg != '0 && pre_reg == acs_pkg::MOD_DIV_LAST)
      cnt_reg <= cnt_reg - acs_pkg::CNT_W'(1);
  end

  assign t.tmr_busy = (cnt_reg != '0);

endmodule
`default_nettype wire

// >>> hw/acs_seq_top.sv
// channel sequencer with axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module acs_seq_top #(
  parameter int unsigned DLY_C3 = acs_pkg::DLY_C3_PERIODS,
  parameter int unsigned DLY_C4 = acs_pkg::DLY_C4_PERIODS,
  parameter int unsigned DLY_C5 = acs_pkg::DLY_C5_PERIODS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        conv_done,
  output var  logic [3:0]  active_chan,
  output var  logic [2:0]  setup_slot,
  output var  logic        conv_start,
  output var  logic        settling,
  output var  logic        filter_reset
);

  acs_core_if core ();

  logic [15:0]              sequence_slot_enable_reg;
  logic                     run_reg;
  logic                     aw_full_reg;
  logic                     w_full_reg;
  logic [7:0]               aw_addr_reg;
  logic [31:0]              w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     rd_pend_reg;
  logic [7:0]               ar_addr_reg;
  logic                     wr_go;
  logic                     cfg_wr;
  acs_pkg::acs_state_t      state_reg;
  logic [acs_pkg::REP_W-1:0] rep_reg;
  logic [acs_pkg::REP_W-1:0] rep_left_reg;
  logic [3:0]               nxt_chan;

  // ----------------------------------------
  // helpers
  // ----------------------------------------

  // setup register window, aligned words only
  function automatic logic is_setup(input logic [7:0] a);
    is_setup = (a >= acs_pkg::OFF_SETUP_BASE) && (a <= acs_pkg::OFF_SETUP_LAST) && (a[1:0] == 2'h0);
  endfunction

  // next enabled channel above cur, else the lowest, else channel 0
  function automatic logic [3:0] next_chan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] res;
    logic       found;
    res = 4'h0;
    found = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (!found && mask[i])
      begin
        res = 4'(i);
        found = 1'b1;
      end
    end
    found = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      if (!found && mask[i] && 4'(i) > cur)
      begin
        res = 4'(i);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------

  // both halves held and no response pending
  assign wr_go  = aw_full_reg && w_full_reg && !bvalid;
  assign cfg_wr = wr_go && (aw_addr_reg == acs_pkg::OFF_CH_EN || is_setup(aw_addr_reg));

  // write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      awready     <= 1'b0;
    end
    else
    begin
      awready <= !aw_full_reg && !(awvalid && awready) && !bvalid;
      if (awvalid && awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      else if (wr_go)
        aw_full_reg <= 1'b0;
    end
  end

  // write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wready     <= 1'b0;
    end
    else
    begin
      wready <= !w_full_reg && !(wvalid && wready) && !bvalid;
      if (wvalid && wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      else if (wr_go)
        w_full_reg <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= acs_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp  <= (cfg_wr || aw_addr_reg == acs_pkg::OFF_CTRL || aw_addr_reg == acs_pkg::OFF_STAT)
                ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // enable mask and run control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sequence_slot_enable_reg <= acs_pkg::CH_EN_RST;
      run_reg                  <= 1'b0;
    end
    else if (wr_go && aw_addr_reg == acs_pkg::OFF_CH_EN)
    begin
      if (w_strb_reg[0])
        sequence_slot_enable_reg[7:0] <= w_data_reg[7:0];
      if (w_strb_reg[1])
        sequence_slot_enable_reg[15:8] <= w_data_reg[15:8];
    end
    else if (wr_go && aw_addr_reg == acs_pkg::OFF_CTRL && w_strb_reg[0])
      run_reg <= w_data_reg[acs_pkg::CTRL_RUN_BIT];
  end

  // setup memory write and read ports
  assign core.we        = wr_go && is_setup(aw_addr_reg);
  assign core.waddr     = aw_addr_reg[5:2];
  assign core.wdata     = w_data_reg[15:0];
  assign core.wbe       = w_strb_reg[1:0];
  assign core.bus_raddr = araddr[5:2];
  assign core.seq_raddr = active_chan;

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready     <= 1'b0;
      rd_pend_reg <= 1'b0;
      ar_addr_reg <= 8'h00;
      rvalid      <= 1'b0;
      rdata       <= 32'h0000_0000;
      rresp       <= acs_pkg::RESP_OKAY;
    end
    else
    begin
      arready     <= !(arvalid && arready) && !rd_pend_reg && !rvalid;
      rd_pend_reg <= arvalid && arready;
      if (arvalid && arready)
        ar_addr_reg <= araddr;
      if (rd_pend_reg)
      begin
        rvalid <= 1'b1;
        rresp  <= acs_pkg::RESP_OKAY;
        rdata  <= 32'h0000_0000;
        if (ar_addr_reg == acs_pkg::OFF_CH_EN)
          rdata[15:0] <= sequence_slot_enable_reg;
        else if (is_setup(ar_addr_reg))
          rdata[15:0] <= core.bus_rdata;
        else if (ar_addr_reg == acs_pkg::OFF_CTRL)
          rdata[acs_pkg::CTRL_RUN_BIT] <= run_reg;
        else if (ar_addr_reg == acs_pkg::OFF_STAT)
        begin
          rdata[acs_pkg::ST_CHAN_LSB +: 4]            <= active_chan;
          rdata[acs_pkg::ST_SLOT_LSB +: 3]            <= setup_slot;
          rdata[acs_pkg::ST_SETTLE_BIT]               <= settling;
          rdata[acs_pkg::ST_CONV_BIT]                 <= (state_reg == acs_pkg::ST_CONV);
          rdata[acs_pkg::ST_RUN_BIT]                  <= run_reg;
          rdata[acs_pkg::ST_REP_LSB +: acs_pkg::REP_W] <= rep_left_reg;
        end
        else
          rresp <= acs_pkg::RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign nxt_chan       = next_chan(sequence_slot_enable_reg, active_chan);
  assign core.tmr_start = (state_reg == acs_pkg::ST_LOAD);
  assign core.tmr_code  = core.seq_rdata[acs_pkg::DLY_LSB +: acs_pkg::DLY_W];

  // filter and control reset pulse on configuration writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      filter_reset <= 1'b0;
    else
      filter_reset <= cfg_wr;
  end

  // channel walk, settling and conversion requests
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg    <= acs_pkg::ST_IDLE;
      active_chan  <= 4'h0;
      setup_slot   <= 3'h0;
      rep_reg      <= 8'h00;
      rep_left_reg <= 8'h00;
      conv_start   <= 1'b0;
      settling     <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (cfg_wr || !run_reg)
      begin
        state_reg <= acs_pkg::ST_IDLE;
        settling  <= 1'b0;
      end
      else
      begin
        case (state_reg)
          acs_pkg::ST_IDLE:
          begin
            active_chan <= next_chan(sequence_slot_enable_reg, 4'hF);
            state_reg   <= acs_pkg::ST_FETCH;
          end
          acs_pkg::ST_FETCH:
            state_reg <= acs_pkg::ST_LOAD;
          acs_pkg::ST_LOAD:
          begin
            setup_slot   <= core.seq_rdata[acs_pkg::SLOT_LSB +: acs_pkg::SLOT_W];
            rep_reg      <= core.seq_rdata[acs_pkg::REP_LSB +: acs_pkg::REP_W];
            rep_left_reg <= core.seq_rdata[acs_pkg::REP_LSB +: acs_pkg::REP_W];
            state_reg    <= acs_pkg::ST_SETTLE;
          end
          acs_pkg::ST_SETTLE:
          begin
            if (!core.tmr_busy)
            begin
              settling   <= 1'b0;
              conv_start <= 1'b1;
              state_reg  <= acs_pkg::ST_CONV;
            end
            else
              settling <= 1'b1; // high only while a wait runs
          end
          acs_pkg::ST_CONV:
          begin
            if (conv_done)
            begin
              if (rep_left_reg != 8'h00)
              begin
                rep_left_reg <= rep_left_reg - 8'h01;
                conv_start   <= 1'b1;
              end
              else if (nxt_chan == active_chan)
              begin
                rep_left_reg <= rep_reg;
                conv_start   <= 1'b1;
              end
              else
              begin
                active_chan <= nxt_chan;
                state_reg   <= acs_pkg::ST_FETCH;
              end
            end
          end
          default:
            state_reg <= acs_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  acs_setup_mem u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .m       (core)
  );

  acs_settle_timer #(
    .DLY_C3 (DLY_C3),
    .DLY_C4 (DLY_C4),
    .DLY_C5 (DLY_C5)
  ) u_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (core)
  );

endmodule
`default_nettype wire

// >>> hw/acs_dummy_end.sv
// spare design unit, holds no logic

// >>> verif/acs_seq_sva.sv
// port-level assertion checker for the channel sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_seq_sva #(
  parameter int unsigned DLY_C3 = acs_pkg::DLY_C3_PERIODS,
  parameter int unsigned DLY_C4 = acs_pkg::DLY_C4_PERIODS,
  parameter int unsigned DLY_C5 = acs_pkg::DLY_C5_PERIODS
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic [3:0] active_chan,
  input wire logic [2:0] setup_slot,
  input wire logic       conv_start,
  input wire logic       settling,
  input wire logic       filter_reset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // bus handshake steps
  // ----------------------------------------
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  sequence s_rd_taken;
    arvalid && arready && !rvalid;
  endsequence

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  chk_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
    else $error("write response not on time");
  chk_read_answer: assert property (s_rd_taken |-> ##2 rvalid)
    else $error("read response not on time");
  chk_ready_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");

  // ----------------------------------------
  // sequencer outputs
  // ----------------------------------------
  chk_reset_pulse: assert property (filter_reset |-> bvalid ##1 !filter_reset)
    else $error("filter reset pulse wrong");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chk_settle_quiet: assert property (settling |-> !conv_start)
    else $error("conversion started while settling");
  chk_settle_min: assert property ($rose(settling) |=> settling [*7])
    else $error("settling ended too early");
  chk_settle_end: assert property ($fell(settling) && !bvalid && !$past(bvalid) |-> ##[0:2] conv_start)
    else $error("no conversion after settling");
  chk_chan_hold: assert property (settling && $past(settling) |-> $stable(active_chan) && $stable(setup_slot))
    else $error("channel changed while settling");
endmodule

bind acs_seq_top acs_seq_sva #(.DLY_C3(DLY_C3), .DLY_C4(DLY_C4), .DLY_C5(DLY_C5)) u_sva (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .active_chan, .setup_slot, .conv_start, .settling, .filter_reset
);
`default_nettype wire

// >>> verif/acs_seq_top_tb_top.sv
// self-checking bench for the channel sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_seq_top_tb_top;
  logic        aclk      = 1'b0;
  logic        aresetn   = 1'b0;
  logic [7:0]  awaddr    = 8'h00;
  logic        awvalid   = 1'b0;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  wstrb     = 4'h0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic [7:0]  araddr    = 8'h00;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic        conv_done = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, conv_start, settling, filter_reset;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [3:0]  active_chan;
  logic [2:0]  setup_slot;
  int          num_errors  = 0;
  int          checks_done = 0;
  // expected walk for mask 0x8025
  localparam logic [3:0] SEQ_CH[8] = '{4'h0, 4'h0, 4'h2, 4'h5, 4'hF, 4'h0, 4'h0, 4'h2};
  localparam logic [2:0] SEQ_SL[8] = '{3'h1, 3'h1, 3'h2, 3'h7, 3'h3, 3'h1, 3'h1, 3'h2};
  localparam int         SEQ_ST[8] = '{64, 0, 32, 0, 48, 64, 0, 32};

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  acs_seq_top #(.DLY_C3(8), .DLY_C4(10), .DLY_C5(12)) dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .conv_done, .active_chan, .setup_slot, .conv_start, .settling, .filter_reset
  );

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic hang();
    num_errors++;
    $display("wrong value wait expected answer seen none");
    tally_and_finish();
  endtask

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er, input logic efr);
    int   n;
    logic fr;
    fr = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      fr = fr | filter_reset;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    if (n == 40)
      hang();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    chk("filter_reset", {31'h0, efr}, {31'h0, fr});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rready <= 1'b0;
    if (n == 40)
      hang();
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // wait one conversion request, check channel, slot and settle length, then finish it
  task automatic cv(input logic [3:0] ch, input logic [2:0] sl, input int st);
    int n;
    int s;
    s = 0;
    for (n = 0; n < 20000; n++)
    begin
      @(posedge aclk);
      if (conv_start)
        break;
      if (settling)
        s++;
    end
    if (n == 20000)
      hang();
    chk("active_chan", {28'h0, ch}, {28'h0, active_chan});
    chk("setup_slot", {29'h0, sl}, {29'h0, setup_slot});
    chk("settle length", st, s);
    repeat (3) @(posedge aclk);
    conv_done <= 1'b1;
    @(posedge aclk);
    conv_done <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge aclk);
    chk("active_chan reset", 32'h0, {28'h0, active_chan});
    aresetn <= 1'b1;
    axi_rd(8'h78, 32'h0000_0001, acs_pkg::RESP_OKAY);
    for (int i = 0; i < 16; i++)
      axi_rd(8'h80 + 8'(4 * i), 32'h0, acs_pkg::RESP_OKAY);
    axi_rd(8'h7C, 32'h0, acs_pkg::RESP_SLVERR);
    axi_rd(8'hC0, 32'h0, acs_pkg::RESP_OKAY);
    axi_wr(8'hD0, 32'h1, 4'hF, acs_pkg::RESP_SLVERR, 1'b0);
    axi_wr(8'h82, 32'h1, 4'hF, acs_pkg::RESP_SLVERR, 1'b0);
    axi_wr(8'h80, 32'hFFFF_FFFF, 4'hF, acs_pkg::RESP_OKAY, 1'b1);
    axi_rd(8'h80, 32'h0000_FF77, acs_pkg::RESP_OKAY);
    axi_wr(8'h80, 32'h0000_1200, 4'h1, acs_pkg::RESP_OKAY, 1'b1);
    axi_rd(8'h80, 32'h0000_FF00, acs_pkg::RESP_OKAY);
    axi_wr(8'h78, 32'h0000_AB00, 4'h2, acs_pkg::RESP_OKAY, 1'b1);
    axi_rd(8'h78, 32'h0000_AB01, acs_pkg::RESP_OKAY);
    // empty mask runs channel 0 only
    axi_wr(8'h80, 32'h0, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h78, 32'h0, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'hC0, 32'h1, 4'h1, acs_pkg::RESP_OKAY, 1'b0);
    repeat (3) cv(4'h0, 3'h0, 0);
    // single channel repeats with one settle only
    axi_wr(8'h90, 32'h0000_0015, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h78, 32'h0000_0010, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    cv(4'h4, 3'h5, 64);
    repeat (2) cv(4'h4, 3'h5, 0);
    // mask 0x8025 with channel 0 kept enabled
    axi_wr(8'h80, 32'h0000_0111, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h88, 32'h0000_0032, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h94, 32'h0000_0067, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'hBC, 32'h0000_0053, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h78, 32'h0000_8025, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    for (int i = 0; i < 8; i++)
      cv(SEQ_CH[i], SEQ_SL[i], SEQ_ST[i]);
    // long delays and a restart in mid settle
    axi_wr(8'h80, 32'h0000_0020, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h84, 32'h0000_0046, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h8C, 32'h0000_0074, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    axi_wr(8'h78, 32'h0000_000B, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    repeat (100) @(posedge aclk);
    chk("settling", 32'h1, {31'h0, settling});
    axi_rd(8'hC4, 32'h0000_0500, acs_pkg::RESP_OKAY);
    axi_wr(8'h78, 32'h0000_000B, 4'h3, acs_pkg::RESP_OKAY, 1'b1);
    cv(4'h0, 3'h0, 4096);
    cv(4'h1, 3'h6, 40);
    cv(4'h3, 3'h4, 0);
    cv(4'h0, 3'h0, 4096);
    axi_wr(8'hC0, 32'h0, 4'h1, acs_pkg::RESP_OKAY, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
